//--- include/pcm_pkg.sv
// shared constants for the power and clock mode controller
`default_nettype none
package pcm_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] SUBQ_OFS = 8'h08;
    // control register fields
    localparam int AMP_STOP_BIT = 0;
    localparam int VCO_STOP_BIT = 1;
    localparam int PPM_LSB = 2;
    localparam int LRS_LSB = 4;
    localparam int RFS_LSB = 8;
    localparam int LOOPBACK_BIT = 11;
    localparam int AMP_CONT_BIT = 12;
    localparam int FORCE_REF_BIT = 13;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_3f3f;
    // status register fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_SRC_PLL_BIT = 4;
    localparam int ST_AMP_ON_BIT = 5;
    localparam int ST_VCO_ON_BIT = 6;
    localparam int ST_LOCK_BIT = 7;
    localparam int ST_SETTLED_BIT = 8;
    // lock ratio and partial power mode encodings
    localparam logic [1:0] LR_256 = 2'h0;
    localparam logic [1:0] LR_384 = 2'h1;
    localparam logic [1:0] LR_512 = 2'h2;
    localparam logic [1:0] LR_512_HALF = 2'h3;
    localparam logic [1:0] PPM_OSC_ONLY = 2'h1;
    localparam logic [1:0] PPM_OSC_DIV = 2'h2;
    // oscillator settle time and bus response codes
    localparam int SETTLE_MS = 10;
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * CLK_MHZ;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        PCM_RESET, PCM_NORMAL, PCM_VCO_STOP, PCM_OSC_ONLY, PCM_OSC_DIV, PCM_AMP_STOP,
        PCM_ALL_STOP
    } pcm_mode_type;
endpackage : pcm_pkg
`default_nettype wire

//--- core/pcm_ctrl.sv
// power, reset and clock source control with an axi4-lite register port
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - power-down low stops clocks, resets registers
// - vco stop alone halts vco, reference clocks
// - mode 01: amplifier only, bit/frame/data low
// - mode 10: amplifier and divider, pins usable
// - amplifier stop overrides partial modes, halts pll
// - partial modes: registers writable; subcode/status read zero
// - vco stop and partial modes use reference
// - amplifier stopped: run from locked pll only
// - both stop bits: all stop, bit/frame clocks hold, master clock low
// - lock ratio field picks pll multiple
// - ratio 11 halves master clock output when running from the pll
// - frequency mismatch still keeps operating
// - loopback uses vco as sole clock source
// - amplifier auto-stops on lock unless continuous or forced to reference
// - pll when locked, else reference; force bit
module pcm_ctrl #(
    parameter int SETTLE_CYCLES = pcm_pkg::SETTLE_CYCLES
) (
    input wire logic aclk, // bus clock, 100 MHz
    input wire logic aresetn, // bus reset, synchronous
    input wire logic system_powerdown_n, // chip power-down pin
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic ref_clock_in, // reference clock level
    input wire logic pll_clock_in, // vco clock level
    input wire logic pll_locked, // pll lock indication
    input wire logic demod_audio_in, // demodulated audio bit
    input wire logic serial_audio_in, // serial audio input
    input wire logic [31:0] subq_status_in, // subcode q / channel status word
    output logic master_clock_out, // master clock
    output logic bit_clock_out, // bit clock
    output logic frame_clock_out, // frame clock
    output logic serial_audio_out, // serial audio output
    output logic osc_drive_out, // oscillator drive
    output logic osc_amp_enable, // oscillator amplifier run
    output logic vco_enable, // vco run
    output logic [1:0] pll_ratio_out // pll multiple select
);
    if (SETTLE_CYCLES < 1) begin : g_settle_check
        $error("SETTLE_CYCLES must be at least one");
    end

    logic pwr_meta_q, pwr_sync_q, rst_n;
    always_ff @(posedge aclk or negedge system_powerdown_n) begin
        if (!system_powerdown_n) begin
            pwr_meta_q <= 1'b0;
            pwr_sync_q <= 1'b0;
        end else begin
            pwr_meta_q <= 1'b1;
            pwr_sync_q <= pwr_meta_q;
        end
    end
    assign rst_n = aresetn & pwr_sync_q;
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        case (addr)
            pcm_pkg::CTRL_OFS: reg_index = 2'h1;
            pcm_pkg::STATUS_OFS: reg_index = 2'h2;
            pcm_pkg::SUBQ_OFS: reg_index = 2'h3;
            default: reg_index = 2'h0;
        endcase
    endfunction : reg_index

    // write channel
    logic [31:0] ctrl_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q, w_have_q, bvalid_q;
    logic [1:0] bresp_q;
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= pcm_pkg::RESP_OKAY;
        end else if (bvalid_q) begin
            if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end else if (aw_have_q && w_have_q) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (reg_index(awaddr_q) == 2'h0) ? pcm_pkg::RESP_SLVERR : pcm_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // control register stays writable in every partial mode
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            ctrl_q <= pcm_pkg::CTRL_RESET;
        end else if (!bvalid_q && aw_have_q && w_have_q && reg_index(awaddr_q) == 2'h1) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_q[b]) begin
                    ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8] & pcm_pkg::CTRL_MASK[b*8 +: 8];
                end
            end
        end
    end
    logic amp_stop, vco_stop, loopback, amp_cont, force_ref;
    logic [1:0] ppm, ratio;
    assign amp_stop = ctrl_q[pcm_pkg::AMP_STOP_BIT];
    assign vco_stop = ctrl_q[pcm_pkg::VCO_STOP_BIT];
    assign ppm = ctrl_q[pcm_pkg::PPM_LSB +: 2];
    assign ratio = ctrl_q[pcm_pkg::LRS_LSB +: 2];
    assign loopback = ctrl_q[pcm_pkg::LOOPBACK_BIT];
    assign amp_cont = ctrl_q[pcm_pkg::AMP_CONT_BIT];
    assign force_ref = ctrl_q[pcm_pkg::FORCE_REF_BIT];
    assign pll_ratio_out = ratio;
    // operating mode from the power bits
    pcm_pkg::pcm_mode_type mode;
    always_comb begin
        if (amp_stop && (vco_stop || ppm != 2'h0)) begin
            mode = pcm_pkg::PCM_ALL_STOP;
        end else if (amp_stop) begin
            mode = pcm_pkg::PCM_AMP_STOP;
        end else if (ppm == pcm_pkg::PPM_OSC_ONLY) begin
            mode = pcm_pkg::PCM_OSC_ONLY;
        end else if (ppm == pcm_pkg::PPM_OSC_DIV) begin
            mode = pcm_pkg::PCM_OSC_DIV;
        end else if (vco_stop) begin
            mode = pcm_pkg::PCM_VCO_STOP;
        end else begin
            mode = pcm_pkg::PCM_NORMAL;
        end
    end

    logic src_pll, running, divider_on, amp_idle;
    always_comb begin
        src_pll = 1'b0;
        running = 1'b1;
        case (mode)
            pcm_pkg::PCM_NORMAL: src_pll = loopback || (pll_locked && !force_ref);
            pcm_pkg::PCM_VCO_STOP, pcm_pkg::PCM_OSC_ONLY, pcm_pkg::PCM_OSC_DIV: begin
                src_pll = 1'b0;
                running = !loopback;
            end
            pcm_pkg::PCM_AMP_STOP: begin
                src_pll = 1'b1;
                running = pll_locked;
            end
            pcm_pkg::PCM_ALL_STOP: running = 1'b0;
            default: running = 1'b0;
        endcase
    end
    assign divider_on = running && mode != pcm_pkg::PCM_OSC_ONLY;
    assign vco_enable = (mode == pcm_pkg::PCM_NORMAL) || (mode == pcm_pkg::PCM_AMP_STOP);
    // crystal sits idle while the locked pll feeds the outputs, unless continuous run is set
    assign amp_idle = mode == pcm_pkg::PCM_NORMAL && src_pll && !loopback && !amp_cont;
    assign osc_amp_enable = !amp_stop && !amp_idle && !loopback;
    assign osc_drive_out = osc_amp_enable ? !ref_clock_in : 1'b1;
    // master clock from rising edges of the chosen source
    logic src_lvl, src_prev_q, src_rise;
    assign src_lvl = src_pll ? pll_clock_in : ref_clock_in;
    assign src_rise = src_lvl && !src_prev_q;
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_lvl;
        end
    end
    logic mclk_q, half_q;
    always_ff @(posedge aclk) begin
        if (!rst_n || !running) begin
            mclk_q <= 1'b0;
            half_q <= 1'b0;
        end else if (src_rise) begin
            half_q <= !half_q;
            if (!(src_pll && ratio == pcm_pkg::LR_512_HALF) || half_q) begin
                mclk_q <= !mclk_q;
            end
        end
    end
    assign master_clock_out = mclk_q;
    // bit and frame dividers; held at last level when everything stops
    logic [8:0] div_q;
    logic mclk_prev_q;
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            div_q <= 9'h000;
            mclk_prev_q <= 1'b0;
        end else if (mode == pcm_pkg::PCM_ALL_STOP) begin
            div_q <= div_q;
        end else if (!divider_on) begin
            div_q <= 9'h000;
            mclk_prev_q <= 1'b0;
        end else begin
            mclk_prev_q <= mclk_q;
            if (mclk_q && !mclk_prev_q) begin
                div_q <= div_q + 9'h001;
            end
        end
    end
    assign bit_clock_out = div_q[1];
    assign frame_clock_out = div_q[8];
    logic sout_q;
    always_ff @(posedge aclk) begin
        if (!rst_n || !divider_on) begin
            sout_q <= 1'b0;
        end else if (mode == pcm_pkg::PCM_OSC_DIV) begin
            sout_q <= serial_audio_in;
        end else begin
            sout_q <= demod_audio_in;
        end
    end
    assign serial_audio_out = sout_q;
    // settle counter after the amplifier restarts
    logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_q;
    logic settled;
    always_ff @(posedge aclk) begin
        if (!rst_n || amp_stop) begin
            settle_q <= '0;
        end else if (!settled) begin
            settle_q <= settle_q + 1'b1;
        end
    end
    assign settled = settle_q == SETTLE_CYCLES[$bits(settle_q)-1:0];

    // read channel
    logic [31:0] status_word, rdata_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[pcm_pkg::ST_MODE_LSB +: 3] = mode;
        status_word[pcm_pkg::ST_SRC_PLL_BIT] = src_pll;
        status_word[pcm_pkg::ST_AMP_ON_BIT] = osc_amp_enable;
        status_word[pcm_pkg::ST_VCO_ON_BIT] = vco_enable;
        status_word[pcm_pkg::ST_LOCK_BIT] = pll_locked;
        status_word[pcm_pkg::ST_SETTLED_BIT] = settled;
    end
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= pcm_pkg::RESP_OKAY;
        end else if (rvalid_q) begin
            if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            rvalid_q <= 1'b1;
            rresp_q <= pcm_pkg::RESP_OKAY;
            case (reg_index(s_axi_araddr))
                2'h1: rdata_q <= ctrl_q;
                2'h2: rdata_q <= status_word;
                2'h3: rdata_q <= (ppm != 2'h0) ? 32'h0000_0000 : subq_status_in;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= pcm_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    a_reset_clears: assert property (@(posedge aclk) !pwr_sync_q |=> ctrl_q == 32'h0000_0000 &&
        !master_clock_out) else $error("power-down did not clear state");
    a_vco_halt: assert property (@(posedge aclk) disable iff (!rst_n)
        mode == pcm_pkg::PCM_VCO_STOP |-> !vco_enable && !src_pll) else $error("vco runs");
    a_osc_only_low: assert property (@(posedge aclk) disable iff (!rst_n)
        mode == pcm_pkg::PCM_OSC_ONLY [*2] |-> !bit_clock_out && !frame_clock_out &&
        !serial_audio_out) else $error("outputs active in oscillator-only mode");
    a_osc_div_serial_audio_in: assert property (@(posedge aclk) disable iff (!rst_n)
        mode == pcm_pkg::PCM_OSC_DIV && !loopback && $stable(mode) |=>
        serial_audio_out == $past(serial_audio_in)) else $error("serial input not passed");
    a_amp_override: assert property (@(posedge aclk) disable iff (!rst_n)
        amp_stop && ppm != 2'h0 |-> !vco_enable && !osc_amp_enable && !running)
        else $error("amplifier stop not dominant");
    a_subq_zero: assert property (@(posedge aclk) disable iff (!rst_n)
        s_axi_rvalid && $rose(s_axi_rvalid) && ppm != 2'h0 && $past(s_axi_araddr) ==
        pcm_pkg::SUBQ_OFS |-> s_axi_rdata == 32'h0000_0000) else $error("subcode not zero");
    a_all_stop_hold: assert property (@(posedge aclk) disable iff (!rst_n)
        mode == pcm_pkg::PCM_ALL_STOP ##1 mode == pcm_pkg::PCM_ALL_STOP |->
        $stable(bit_clock_out) && $stable(frame_clock_out)) else $error("clocks moved");
    a_amp_unlock_stop: assert property (@(posedge aclk) disable iff (!rst_n)
        mode == pcm_pkg::PCM_AMP_STOP && !pll_locked |=> !master_clock_out)
        else $error("clock runs unlocked without amplifier");
    a_source_select: assert property (@(posedge aclk) disable iff (!rst_n)
        mode == pcm_pkg::PCM_NORMAL && !loopback |-> src_pll == (pll_locked && !force_ref))
        else $error("wrong clock source");
    a_amp_auto_stop: assert property (@(posedge aclk) disable iff (!rst_n)
        mode == pcm_pkg::PCM_NORMAL && pll_locked && !force_ref && !loopback |->
        osc_amp_enable == amp_cont) else $error("amplifier auto-stop wrong");
    a_loop_vco: assert property (@(posedge aclk) disable iff (!rst_n)
        loopback && mode == pcm_pkg::PCM_NORMAL |-> src_pll && !osc_amp_enable)
        else $error("loopback not on vco");
endmodule : pcm_ctrl
`default_nettype wire

//--- sim/pcm_far_model.sv
// far-side model: power-down pin, reference clock and pll
`timescale 1ns/10ps
`default_nettype none
module pcm_far_model (
    input wire logic aclk, // bench clock
    input wire logic pwr_req, // bench asks for power-down
    input wire logic lock_req, // bench asks for pll lock
    input wire logic vco_enable, // vco run level from the device
    output logic system_powerdown_n, // power-down pin
    output logic ref_clock_in, // reference clock
    output logic pll_clock_in, // vco clock
    output logic pll_locked // lock level
);
    logic [1:0] ref_cnt_q = 2'h0;
    // pin starts low so the device comes up in reset
    logic pwr_n_q = 1'b0, ref_q = 1'b0, vco_q = 1'b0, lock_q = 1'b0;
    assign system_powerdown_n = pwr_n_q;
    assign ref_clock_in = ref_q;
    assign pll_clock_in = vco_q;
    assign pll_locked = lock_q;
    // reference toggles every third cycle and never pauses
    always @(posedge aclk) begin
        ref_cnt_q <= (ref_cnt_q == 2'h2) ? 2'h0 : ref_cnt_q + 2'h1;
        if (ref_cnt_q == 2'h2) ref_q <= ~ref_q;
    end
    // a stopped vco neither runs nor stays locked
    always @(posedge aclk) begin
        pwr_n_q <= ~pwr_req;
        vco_q <= vco_enable ? ~vco_q : vco_q;
        lock_q <= lock_req && vco_enable;
    end
endmodule : pcm_far_model
`default_nettype wire

//--- sim/power_and_clock_mode_control_tb_top.sv
// testbench for the power and clock mode controller
`timescale 1ns/10ps
`default_nettype none
module power_and_clock_mode_control_tb_top;
    localparam int SETTLE = 20;
    localparam logic [7:0] C = pcm_pkg::CTRL_OFS;
    localparam logic [7:0] S = pcm_pkg::STATUS_OFS;
    localparam logic [7:0] Q = pcm_pkg::SUBQ_OFS;
    localparam logic [1:0] OK = pcm_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = pcm_pkg::RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0, pwr_req = 1'b1, lock_req = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, subq = 32'ha5a5_5a5a;
    logic demod = 1'b0, ser_in = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, pwr_n, refc, pllc, locked;
    logic mclk, bclk, fclk, sdout, osc_drv, amp_en, vco_en;
    logic [1:0] bresp, rresp, ratio;
    logic [31:0] rdata;
    int num_errors = 0, compares = 0, cycles = 0;
    always #5 aclk = ~aclk;
    pcm_ctrl #(.SETTLE_CYCLES(SETTLE)) pcm_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .system_powerdown_n(pwr_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ref_clock_in(refc), .pll_clock_in(pllc), .pll_locked(locked),
        .demod_audio_in(demod), .serial_audio_in(ser_in), .subq_status_in(subq),
        .master_clock_out(mclk), .bit_clock_out(bclk), .frame_clock_out(fclk),
        .serial_audio_out(sdout), .osc_drive_out(osc_drv), .osc_amp_enable(amp_en),
        .vco_enable(vco_en), .pll_ratio_out(ratio));
    pcm_far_model pcm_far_model_inst (.aclk(aclk), .pwr_req(pwr_req), .lock_req(lock_req),
        .vco_enable(vco_en), .system_powerdown_n(pwr_n), .ref_clock_in(refc),
        .pll_clock_in(pllc), .pll_locked(locked));
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    always @(posedge aclk) begin
        demod <= ~demod;
        ser_in <= demod;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // ready is looked at before the edge, so the edge itself completes the transfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_h, w_h, aw_d, w_d;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_d = 1'b0;
        w_d = 1'b0;
        while (!(aw_d && w_d)) begin
            @(negedge aclk);
            aw_h = !aw_d && awready;
            w_h = !w_d && wready;
            @(posedge aclk);
            if (aw_h) awvalid <= 1'b0;
            if (w_h) wvalid <= 1'b0;
            aw_d = aw_d || aw_h;
            w_d = w_d || w_h;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        check("bresp", 32'(bresp), 32'(er));
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic h;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        h = 1'b0;
        while (!h) begin
            @(negedge aclk);
            h = (arready === 1'b1);
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        check(nm, rdata & m, e);
        check("rresp", 32'(rresp), 32'((a > Q) ? ERR : OK));
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rc
    // counts level changes of one output: 3 master, 2 bit, 1 frame, 0 serial data
    task automatic tog(input int which, output int n);
        logic [3:0] prev, cur;
        n = 0;
        repeat (4) @(negedge aclk);
        prev = {mclk, bclk, fclk, sdout};
        repeat (160) begin
            @(negedge aclk);
            cur = {mclk, bclk, fclk, sdout};
            if (cur[which] !== prev[which]) n++;
            prev = cur;
        end
    endtask : tog
    initial begin
        int n, n2;
        repeat (2) @(posedge aclk);
        pwr_req <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (SETTLE + 5) @(posedge aclk);
        rc("ctrl reset", C, 32'hffff_ffff, 32'h0);
        rc("mode normal", S, 32'h7, 32'h1);
        wr(8'h0c, 32'h1, ERR);
        rc("unmapped", 8'h0c, 32'hffff_ffff, 32'h0);
        wr(S, 32'hffff_ffff, OK);
        rc("status kept", S, 32'h7, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(C, 32'(i << 4), OK);
            rc("ratio field", C, 32'h30, 32'(i << 4));
            check("pll ratio", 32'(ratio), 32'(i));
        end
        lock_req <= 1'b1;
        wr(C, 32'h0, OK);
        tog(3, n);
        check("pll rate", 32'(n > 33), 1);
        rc("src pll", S, 32'h10, 32'h10);
        check("amp auto stop", 32'(amp_en), 0);
        wr(C, 32'h1000, OK);
        check("amp continuous", 32'(amp_en), 1);
        wr(C, 32'h30, OK);
        tog(3, n2);
        check("half mclk", 32'(n > 2 * n2 - 3 && n < 2 * n2 + 3), 1);
        wr(C, 32'h2000, OK);
        tog(3, n);
        check("forced ref", 32'(n > 0 && n < 33), 1);
        check("osc drive run", 32'(osc_drv), 32'(!refc));
        rc("src ref", S, 32'h10, 32'h0);
        wr(C, 32'h2, OK);
        tog(3, n);
        check("vco stop ref", 32'(n > 0 && n < 33), 1);
        check("vco off", 32'(vco_en), 0);
        rc("vco mode", S, 32'h17, 32'h2);
        wr(C, 32'h1, OK);
        tog(3, n);
        check("amp stop locked", 32'(n > 33), 1);
        rc("amp stop mode", S, 32'h17, 32'h15);
        lock_req <= 1'b0;
        tog(3, n);
        check("amp stop unlocked", 32'(n), 0);
        wr(C, 32'h0, OK);
        rc("not settled", S, 32'h100, 32'h0);
        repeat (SETTLE + 5) @(posedge aclk);
        rc("settled", S, 32'h100, 32'h100);
        wr(C, 32'hffff_c1c4, OK);
        rc("ctrl in ppm", C, 32'hffff_ffff, 32'h104);
        rc("subq zero", Q, 32'hffff_ffff, 32'h0);
        tog(2, n);
        check("bclk stopped", 32'(n), 0);
        check("low pins", 32'({bclk, fclk, sdout}), 0);
        rc("osc only mode", S, 32'h7, 32'h3);
        wr(C, 32'h8, OK);
        tog(2, n);
        check("bclk runs", 32'(n > 0), 1);
        rc("osc div mode", S, 32'h7, 32'h4);
        wr(C, 32'h9, OK);
        tog(3, n);
        check("amp over ppm", 32'(n), 0);
        check("pll halted", 32'({amp_en, vco_en}), 0);
        check("osc drive stop", 32'(osc_drv), 1);
        wr(C, 32'h0, OK);
        tog(2, n);
        @(negedge aclk);
        wr(C, 32'h3, OK);
        @(negedge aclk);
        n2 = 32'({bclk, fclk});
        tog(1, n);
        check("frame held", 32'(n), 0);
        check("clocks held", 32'({bclk, fclk}), 32'(n2));
        rc("all stop mode", S, 32'h7, 32'h6);
        wr(C, 32'h800, OK);
        tog(3, n);
        check("loopback vco", 32'(n > 33), 1);
        wr(C, 32'h802, OK);
        tog(3, n);
        check("loopback stop", 32'(n), 0);
        wr(C, 32'h2030, OK);
        pwr_req <= 1'b1;
        tog(3, n);
        check("powerdown clocks", 32'(n) | 32'({mclk, ratio}), 0);
        pwr_req <= 1'b0;
        repeat (SETTLE + 3) @(posedge aclk);
        rc("ctrl after powerdown", C, 32'hffff_ffff, 32'h0);
        wrap_up();
    end
endmodule : power_and_clock_mode_control_tb_top
`default_nettype wire
